// [low_power_mode_wakeup_test.sv]
`timescale 1ns/1ps
`include "lpmw_defines.svh"
module low_power_mode_wakeup_test;
    logic        sys_clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic        nmi_pin, porta_pin, portbc_pin, timer_irq, conv_irq, wdg_active;
    logic        cpu_sleep, cpu_sleep_stop, cpu_vec_ack, cpu_reti, cpu_clk_en, cpu_vec_req;
    logic        osc_en, osc_aux_sel, periph_clk_en, wdg_freeze;
    logic [1:0]  htrans, cpu_ctx;
    logic [3:0]  ack_dly;
    logic [11:0] cpu_vec_addr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          mismatches, comparisons, k;

    lpmw_ctrl u_dut (.SYS_CLK(sys_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .NMI_PIN(nmi_pin), .PORTA_PIN(porta_pin), .PORTBC_PIN(portbc_pin),
        .TIMER_ZERO_IRQ(timer_irq), .CONV_DONE_IRQ(conv_irq), .WDG_ACTIVE(wdg_active),
        .CPU_SLEEP(cpu_sleep), .CPU_SLEEP_STOP(cpu_sleep_stop), .CPU_VEC_ACK(cpu_vec_ack),
        .CPU_RETI(cpu_reti), .CPU_CLK_EN(cpu_clk_en), .CPU_VEC_REQ(cpu_vec_req),
        .CPU_VEC_ADDR(cpu_vec_addr), .CPU_CTX(cpu_ctx), .OSC_EN(osc_en),
        .OSC_AUX_SEL(osc_aux_sel), .PERIPH_CLK_EN(periph_clk_en), .WDG_FREEZE(wdg_freeze));
    lpmw_cpu_model u_cpu (.sys_clk(sys_clk), .nrst(nrst), .vec_req(cpu_vec_req),
        .clk_en(cpu_clk_en), .vec_ack(cpu_vec_ack), .ack_dly(ack_dly));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        cyc(1);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    // level sources model a flag that software clears inside the routine
    task automatic src(input int s, input logic on);
        case (s)
            0: nmi_pin <= !on;
            1: porta_pin <= !on;
            2: portbc_pin <= !on;
            3: timer_irq <= on;
            default: conv_irq <= on;
        endcase
    endtask
    function automatic logic [11:0] exp_vec(input int s);
        case (s)
            0: return `LPMW_VEC_NMI;
            1: return `LPMW_VEC_PORTA;
            2: return `LPMW_VEC_PORTBC;
            3: return `LPMW_VEC_TIMER;
            default: return `LPMW_VEC_CONV;
        endcase
    endfunction
    // bound covers the start-up delay after stop
    task automatic wait_vec(input logic [11:0] exp, input logic [1:0] ctx);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!(cpu_vec_req === 1'b1 && cpu_vec_ack === 1'b1) && n < 3000);
        if (n >= 3000) mismatches++;
        chk({20'h0, cpu_vec_addr}, {20'h0, exp});
        repeat (2) @(negedge sys_clk);
        chk({30'h0, cpu_ctx}, {30'h0, ctx});
    endtask
    task automatic sleep(input logic stop);
        cyc(1);
        cpu_sleep      <= 1'b1;
        cpu_sleep_stop <= stop;
        cyc(1);
        cpu_sleep <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic reti();
        cyc(1);
        cpu_reti <= 1'b1;
        cyc(1);
        cpu_reti <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic warm_len();
        int n;
        n = 0;
        while (osc_en !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        chk({31'h0, n inside {[2048:2049]}}, 32'h1);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // whole run needs about 5000 cycles
    initial begin
        #(3000000);
        mismatches++;
        conclude();
    end
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {nmi_pin, porta_pin, portbc_pin} = 3'b111;
        {timer_irq, conv_irq, wdg_active, cpu_sleep, cpu_sleep_stop, cpu_reti} = '0;
        ack_dly = 4'h0;
        mismatches = 0;
        comparisons = 0;
        void'($urandom(32'hd6c5));
        cyc(5);
        nrst <= 1'b1;
        wait_vec(`LPMW_VEC_RST, 2'd0);
        chk({29'h0, osc_en, periph_clk_en, cpu_clk_en}, 32'h7);
        ahb(1'b1, `LPMW_OFS_IOPT, 32'h10, rd);
        ahb(1'b0, `LPMW_OFS_IOPT, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        chk(rd, 32'h0);
        for (int i = 0; i < 12; i++) begin
            k = (i < 5) ? i : int'($urandom_range(4));
            ack_dly <= 4'($urandom_range(9));
            cyc(1);
            src(k, 1'b1);
            wait_vec(exp_vec(k), (k == 0) ? 2'd2 : 2'd1);
            cyc(1);
            src(k, 1'b0);
            reti();
            chk({30'h0, cpu_ctx}, 32'h0);
        end
        cyc(1);
        src(3, 1'b1);
        src(4, 1'b1);
        wait_vec(`LPMW_VEC_TIMER, 2'd1);
        cyc(1);
        src(3, 1'b0);
        sleep(1'b0);
        chk({31'h0, cpu_clk_en}, 32'h1);
        cyc(20);
        chk({31'h0, cpu_vec_req}, 32'h0);
        src(0, 1'b1);
        wait_vec(`LPMW_VEC_NMI, 2'd2);
        cyc(1);
        src(0, 1'b0);
        reti();
        chk({30'h0, cpu_ctx}, 32'h1);
        reti();
        wait_vec(`LPMW_VEC_CONV, 2'd1);
        cyc(1);
        src(4, 1'b0);
        reti();
        ahb(1'b1, `LPMW_OFS_OPTION, 32'h2, rd);
        ahb(1'b0, `LPMW_OFS_OPTION, 32'h0, rd);
        chk(rd, 32'h2);
        sleep(1'b0);
        chk({28'h0, cpu_clk_en, osc_en, osc_aux_sel, periph_clk_en}, 32'h7);
        ahb(1'b0, `LPMW_OFS_STATUS, 32'h0, rd);
        chk(rd & 32'h7, 32'h2);
        src(4, 1'b1);
        wait_vec(`LPMW_VEC_CONV, 2'd1);
        cyc(1);
        src(4, 1'b0);
        reti();
        ahb(1'b1, `LPMW_OFS_OPTION, 32'h0, rd);
        sleep(1'b1);
        chk({29'h0, cpu_clk_en, osc_en, periph_clk_en}, 32'h0);
        cyc(1);
        src(4, 1'b1);
        cyc(40);
        chk({31'h0, osc_en}, 32'h0);
        src(4, 1'b0);
        src(3, 1'b1);
        warm_len();
        wait_vec(`LPMW_VEC_TIMER, 2'd1);
        cyc(1);
        src(3, 1'b0);
        wdg_active <= 1'b1;
        reti();
        sleep(1'b1);
        chk({30'h0, osc_en, wdg_freeze}, 32'h2);
        src(1, 1'b1);
        wait_vec(`LPMW_VEC_PORTA, 2'd1);
        cyc(1);
        src(1, 1'b0);
        reti();
        ahb(1'b1, `LPMW_OFS_OPTION, 32'h1, rd);
        sleep(1'b1);
        chk({30'h0, osc_en, wdg_freeze}, 32'h1);
        src(0, 1'b1);
        wait_vec(`LPMW_VEC_NMI, 2'd2);
        cyc(1);
        src(0, 1'b0);
        wdg_active <= 1'b0;
        reti();
        ahb(1'b1, `LPMW_OFS_IOPT, 32'h0, rd);
        sleep(1'b0);
        src(0, 1'b1);
        cyc(30);
        chk({31'h0, cpu_clk_en}, 32'h0);
        src(0, 1'b0);
        ahb(1'b1, `LPMW_OFS_IOPT, 32'h10, rd);
        wait_vec(`LPMW_VEC_NMI, 2'd2);
        sleep(1'b0);
        src(3, 1'b1);
        cyc(10);
        chk({28'h0, cpu_clk_en, cpu_vec_req, cpu_ctx}, 32'ha);
        src(3, 1'b0);
        reti();
        ahb(1'b1, `LPMW_OFS_IOPT, 32'h70, rd);
        src(2, 1'b1);
        cyc(5);
        src(2, 1'b0);
        wait_vec(`LPMW_VEC_PORTBC, 2'd1);
        reti();
        src(1, 1'b1);
        wait_vec(`LPMW_VEC_PORTA, 2'd1);
        cyc(1);
        src(1, 1'b0);
        reti();
        conclude();
    end
endmodule

// [lpmw_cpu_model.sv]
`timescale 1ns/1ps
module lpmw_cpu_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // vector handshake with the controller
    input  wire logic       vec_req,
    input  wire logic       clk_en,
    output logic            vec_ack,
    // bench control: cycles to hold off each ack
    input  wire logic [3:0] ack_dly
);
    logic [3:0] cnt_r;
    logic       armed_r;
    // re-arm only once the request drops, so one request is never acked twice
    // a halted core has no clock, so it never acks while clk_en is low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r   <= 4'h0;
            armed_r <= 1'b1;
            vec_ack <= 1'b0;
        end else begin
            vec_ack <= 1'b0;
            if (!vec_req) begin
                armed_r <= 1'b1;
                cnt_r   <= 4'h0;
            end else if (clk_en && armed_r) begin
                if (cnt_r >= ack_dly) begin
                    vec_ack <= 1'b1;
                    armed_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule

// [lpmw_ctrl.sv]
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "lpmw_defines.svh"
// How it works
// R01: reset vector FFEh, non-maskable FFCh, port A FF6h; FFAh and FF8h unused.
// R02: port B/C vector FF4h, timer FF2h, converter end-of-conversion FF0h.
// R03: only reset, non-maskable, port and timer requests end stop; converter never does.
// R04: after any reset the block enters run mode with the main oscillator clocking all.
// R05: wait instruction halts the core at once until a wake-up event.
// R06: during wait the selected oscillator keeps running and peripherals stay clocked.
// R07: wait ends on reset, any peripheral interrupt, port or non-maskable interrupt.
// R08: leaving sleep, the core is steered to the waking service routine or reset.
// R09: stop freezes the core and stops the oscillator and peripheral clock.
// R10: stop ends on reset, port or non-maskable request, or externally clocked peripheral.
// R11: every stop exit waits 2048 internal cycles before execution resumes.
// R12: with watchdog active, stop acts as wait unless option set and nmi pin high.
// R13: watchdog active, option set, nmi pin high: real stop and watchdog frozen.
// R14: with global enable low, nmi still serviced but cannot wake from sleep.
// R15: sleep from main: waking routine runs first, then code after the sleep.
// R16: sleep in nmi routine: any request wakes, stays in nmi context, not serviced.
// R17: sleep in normal routine woken by normal request: routine continues, pending later.
// R18: sleep in normal routine woken by nmi: nmi routine first, then original routine.
// R19: a sleep instruction with an enabled request already pending does nothing.
// R20: fixed priority port A, port B/C, timer, converter; no maskable preemption.
// R21: global enable is bit 4 of the write-only interrupt option register.
// R22: falling nmi edge sets a latch cleared when the nmi routine starts.
// R23: pin wake-up needs no oscillator clock; request resolved after start-up delay.
module lpmw_ctrl (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // external pins, asynchronous
    input  wire logic        NMI_PIN,
    input  wire logic        PORTA_PIN,
    input  wire logic        PORTBC_PIN,
    // peripherals and watchdog, same clock
    input  wire logic        TIMER_ZERO_IRQ,
    input  wire logic        CONV_DONE_IRQ,
    input  wire logic        WDG_ACTIVE,
    // cpu core
    input  wire logic        CPU_SLEEP,
    input  wire logic        CPU_SLEEP_STOP,
    input  wire logic        CPU_VEC_ACK,
    input  wire logic        CPU_RETI,
    output logic             CPU_CLK_EN,
    output logic             CPU_VEC_REQ,
    output logic      [11:0] CPU_VEC_ADDR,
    output logic      [1:0]  CPU_CTX,
    // clocks and watchdog control
    output logic             OSC_EN,
    output logic             OSC_AUX_SEL,
    output logic             PERIPH_CLK_EN,
    output logic             WDG_FREEZE
);

    // pin synchronisers: stage 0 is read only by stage 1
    logic [2:0] pin_raw;
    logic [2:0] sync0_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    assign pin_raw = {PORTBC_PIN, PORTA_PIN, NMI_PIN};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge SYS_CLK or negedge NRST) begin
                if (!NRST) begin
                    sync0_r[gi] <= 1'b1;
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                end else begin
                    sync0_r[gi] <= pin_raw[gi];
                    sync1_r[gi] <= sync0_r[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // registers
    logic [7:0]              iopt_r;
    logic [1:0]              opt_r;
    lpmw_pkg::lpmw_state_e   state_r;
    lpmw_pkg::lpmw_state_e   state_nxt;
    lpmw_pkg::lpmw_ctx_e     ctx_r;
    lpmw_pkg::lpmw_ctx_e     ctx_nxt;
    lpmw_pkg::lpmw_vkind_e   vkind_r;
    lpmw_pkg::lpmw_vkind_e   vkind_nxt;
    logic                    nmi_from_int_r;
    logic                    nmi_lat_r;
    logic                    porta_lat_r;
    logic                    portbc_lat_r;
    logic [`LPMW_WARM_W-1:0] warm_cnt_r;

    // edge detection on synchronised pins
    logic nmi_fall;
    logic porta_fall;
    logic portbc_edge;
    logic nmi_high;
    logic gie;
    logic les;
    logic esb;
    assign gie         = iopt_r[`LPMW_IOPT_GIE_BIT];                        // R21
    assign les         = iopt_r[`LPMW_IOPT_LES_BIT];
    assign esb         = iopt_r[`LPMW_IOPT_ESB_BIT];
    assign nmi_high    = sync1_r[0];
    assign nmi_fall    = sync2_r[0] & ~sync1_r[0];                          // R22
    assign porta_fall  = sync2_r[1] & ~sync1_r[1];
    assign portbc_edge = esb ? (~sync2_r[2] & sync1_r[2]) : (sync2_r[2] & ~sync1_r[2]);

    // request view
    logic req_a;
    logic req_bc;
    logic any_mask;
    logic nmi_go;
    logic mask_ok;
    logic want_vec;
    logic vec_ack;
    logic sleep_block;
    logic wake_wait;
    logic wake_stop;
    logic sleep_ok;
    logic real_stop;
    // port a level mode cannot be stored: the low level must be present
    assign req_a       = les ? ~sync1_r[1] : porta_lat_r;
    assign req_bc      = portbc_lat_r;
    assign any_mask    = req_a | req_bc | TIMER_ZERO_IRQ | CONV_DONE_IRQ;
    assign nmi_go      = nmi_lat_r & (ctx_r != lpmw_pkg::CTX_NMI);
    // maskable routines never preempt each other or the nmi routine
    assign mask_ok     = gie & (ctx_r == lpmw_pkg::CTX_MAIN) & any_mask;    // R20
    assign want_vec    = (state_r == lpmw_pkg::ST_BOOT)
                       | ((state_r == lpmw_pkg::ST_RUN) & (nmi_go | mask_ok));
    assign vec_ack     = CPU_VEC_REQ & CPU_VEC_ACK;
    assign sleep_block = nmi_go | (gie & any_mask);                         // R19
    assign sleep_ok    = CPU_SLEEP & (state_r == lpmw_pkg::ST_RUN) & ~CPU_VEC_REQ & ~sleep_block;
    // with gie low nothing wakes; nmi still serviced while running
    assign wake_wait   = gie & (nmi_lat_r | any_mask);                      // R07 R14 R16
    assign wake_stop   = gie & (nmi_lat_r | req_a | req_bc | TIMER_ZERO_IRQ); // R03 R10 R14
    assign real_stop   = CPU_SLEEP_STOP
                       & (~WDG_ACTIVE | (opt_r[`LPMW_OPT_EXSTOP_BIT] & nmi_high)); // R12 R13

    // vector selection, fixed priority
    assign vkind_nxt = (state_r == lpmw_pkg::ST_BOOT) ? lpmw_pkg::VK_RST :
                       nmi_go                         ? lpmw_pkg::VK_NMI :     // R18
                       req_a                          ? lpmw_pkg::VK_PORTA :   // R20
                       req_bc                         ? lpmw_pkg::VK_PORTBC :
                       TIMER_ZERO_IRQ                 ? lpmw_pkg::VK_TIMER :
                                                        lpmw_pkg::VK_CONV;

    logic [11:0] vec_addr_nxt;
    assign vec_addr_nxt = (vkind_nxt == lpmw_pkg::VK_RST)    ? `LPMW_VEC_RST :    // R01
                          (vkind_nxt == lpmw_pkg::VK_NMI)    ? `LPMW_VEC_NMI :    // R01
                          (vkind_nxt == lpmw_pkg::VK_PORTA)  ? `LPMW_VEC_PORTA :  // R01
                          (vkind_nxt == lpmw_pkg::VK_PORTBC) ? `LPMW_VEC_PORTBC : // R02
                          (vkind_nxt == lpmw_pkg::VK_TIMER)  ? `LPMW_VEC_TIMER :  // R02
                                                               `LPMW_VEC_CONV;    // R02

    // power state machine
    logic warm_done;
    assign warm_done = (warm_cnt_r == '0);
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            lpmw_pkg::ST_BOOT: begin
                if (vec_ack) begin
                    state_nxt = lpmw_pkg::ST_RUN;                           // R04
                end
            end
            lpmw_pkg::ST_RUN: begin
                if (sleep_ok) begin
                    state_nxt = real_stop ? lpmw_pkg::ST_STOP : lpmw_pkg::ST_WAIT; // R05 R09 R12
                end
            end
            lpmw_pkg::ST_WAIT: begin
                if (wake_wait) begin
                    state_nxt = lpmw_pkg::ST_RUN;                           // R07 R08
                end
            end
            lpmw_pkg::ST_STOP: begin
                if (wake_stop) begin
                    state_nxt = lpmw_pkg::ST_WARM;                          // R10 R23
                end
            end
            lpmw_pkg::ST_WARM: begin
                if (warm_done) begin
                    state_nxt = lpmw_pkg::ST_RUN;                           // R11
                end
            end
            default: state_nxt = lpmw_pkg::ST_BOOT;
        endcase
    end

    // interrupt context: dispatcher after wake gives the restart order
    always_comb begin
        ctx_nxt = ctx_r;
        if (vec_ack && vkind_r == lpmw_pkg::VK_NMI) begin
            ctx_nxt = lpmw_pkg::CTX_NMI;                                    // R18
        end else if (vec_ack && vkind_r != lpmw_pkg::VK_RST) begin
            ctx_nxt = lpmw_pkg::CTX_INT;                                    // R15
        end else if (CPU_RETI && ctx_r == lpmw_pkg::CTX_NMI) begin
            ctx_nxt = nmi_from_int_r ? lpmw_pkg::CTX_INT : lpmw_pkg::CTX_MAIN; // R18
        end else if (CPU_RETI) begin
            ctx_nxt = lpmw_pkg::CTX_MAIN;                                   // R17
        end
    end

    // latches: a new edge wins over the clear on acknowledge
    logic clr_nmi;
    logic clr_a;
    logic clr_bc;
    assign clr_nmi = vec_ack & (vkind_r == lpmw_pkg::VK_NMI);
    assign clr_a   = vec_ack & (vkind_r == lpmw_pkg::VK_PORTA);
    assign clr_bc  = vec_ack & (vkind_r == lpmw_pkg::VK_PORTBC);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            nmi_lat_r    <= 1'b0;
            porta_lat_r  <= 1'b0;
            portbc_lat_r <= 1'b0;
        end else begin
            nmi_lat_r    <= nmi_fall | (nmi_lat_r & ~clr_nmi);              // R22
            porta_lat_r  <= porta_fall | (porta_lat_r & ~clr_a);
            portbc_lat_r <= portbc_edge | (portbc_lat_r & ~clr_bc);
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_r        <= lpmw_pkg::ST_BOOT;                            // R04
            ctx_r          <= lpmw_pkg::CTX_MAIN;
            vkind_r        <= lpmw_pkg::VK_RST;
            nmi_from_int_r <= 1'b0;
            warm_cnt_r     <= '0;
        end else begin
            state_r <= state_nxt;
            ctx_r   <= ctx_nxt;
            if (!CPU_VEC_REQ) begin
                vkind_r <= vkind_nxt;
            end
            if (vec_ack && vkind_r == lpmw_pkg::VK_NMI) begin
                nmi_from_int_r <= (ctx_r == lpmw_pkg::CTX_INT);
            end
            if (state_nxt == lpmw_pkg::ST_WARM && state_r != lpmw_pkg::ST_WARM) begin
                warm_cnt_r <= `LPMW_WARM_LOAD;                              // R11
            end else if (!warm_done) begin
                warm_cnt_r <= warm_cnt_r - 1'b1;
            end
        end
    end

    // registered outputs to core and clock tree
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            CPU_CLK_EN    <= 1'b1;
            CPU_VEC_REQ   <= 1'b0;
            CPU_VEC_ADDR  <= `LPMW_VEC_RST;
            CPU_CTX       <= 2'h0;
            OSC_EN        <= 1'b1;
            OSC_AUX_SEL   <= 1'b0;
            PERIPH_CLK_EN <= 1'b1;
            WDG_FREEZE    <= 1'b0;
        end else begin
            CPU_CLK_EN    <= (state_nxt == lpmw_pkg::ST_RUN) | (state_nxt == lpmw_pkg::ST_BOOT); // R05
            // drop the request for one cycle after ack so the next pick sees cleared latches
            CPU_VEC_REQ   <= want_vec & ~vec_ack & (state_nxt == state_r);  // R08
            if (!CPU_VEC_REQ) begin
                CPU_VEC_ADDR <= vec_addr_nxt;
            end
            CPU_CTX       <= ctx_nxt;
            OSC_EN        <= (state_nxt != lpmw_pkg::ST_STOP);              // R06 R09
            OSC_AUX_SEL   <= opt_r[`LPMW_OPT_AUXOSC_BIT];                   // R06
            PERIPH_CLK_EN <= (state_nxt != lpmw_pkg::ST_STOP) & (state_nxt != lpmw_pkg::ST_WARM);
            WDG_FREEZE    <= (state_nxt == lpmw_pkg::ST_STOP) & WDG_ACTIVE; // R13
        end
    end

    // ahb-lite slave: zero wait states, reads fetched in the address phase
    logic        ahb_go;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] status_w;
    logic [31:0] rd_mux;
    assign ahb_go   = HSEL & HTRANS[1] & HREADY;
    assign status_w = {23'h0, nmi_from_int_r, portbc_lat_r, porta_lat_r, nmi_lat_r,
                       ctx_r, state_r};
    // the interrupt option register is write-only and reads back as zero
    assign rd_mux   = (HADDR[7:0] == `LPMW_OFS_OPTION) ? {30'h0, opt_r} :
                      (HADDR[7:0] == `LPMW_OFS_STATUS) ? status_w : 32'h0;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            iopt_r    <= `LPMW_IOPT_RESET;
            opt_r     <= `LPMW_OPT_RESET;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            HRDATA    <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            wr_pend_r <= ahb_go & HWRITE;
            wr_addr_r <= HADDR[7:0];
            if (ahb_go && !HWRITE) begin
                HRDATA <= rd_mux;
            end
            if (wr_pend_r && wr_addr_r == `LPMW_OFS_IOPT) begin
                iopt_r <= {1'b0, HWDATA[6:4], 4'h0};                        // R21
            end
            if (wr_pend_r && wr_addr_r == `LPMW_OFS_OPTION) begin
                opt_r <= HWDATA[1:0];
            end
        end
    end

    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    logic [`LPMW_WARM_W-1:0] chk_warm_r;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            chk_warm_r <= '0;
        end else if (state_r == lpmw_pkg::ST_WARM) begin
            chk_warm_r <= chk_warm_r + 1'b1;
        end else begin
            chk_warm_r <= '0;
        end
    end

    property p_boot_vec;
        (state_r == lpmw_pkg::ST_BOOT) && CPU_VEC_REQ |-> CPU_VEC_ADDR == 12'hffe;
    endproperty
    a_boot_vec: assert property (p_boot_vec) else $error("reset vector wrong"); // R01
    property p_nmi_vec;
        CPU_VEC_REQ && vkind_r == lpmw_pkg::VK_NMI |-> CPU_VEC_ADDR == 12'hffc;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong"); // R01
    property p_timer_vec;
        CPU_VEC_REQ && vkind_r == lpmw_pkg::VK_TIMER |-> CPU_VEC_ADDR == 12'hff2;
    endproperty
    a_timer_vec: assert property (p_timer_vec) else $error("timer vector wrong"); // R02
    property p_stop_exit;
        (state_r == lpmw_pkg::ST_STOP) ##1 (state_r != lpmw_pkg::ST_STOP)
            |-> $past(wake_stop) && state_r == lpmw_pkg::ST_WARM;
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("bad stop exit"); // R03
    property p_warm_len;
        (state_r == lpmw_pkg::ST_WARM) ##1 (state_r == lpmw_pkg::ST_RUN)
            |-> $past(chk_warm_r) == 12'h7ff;
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("start-up delay not 2048"); // R11
    property p_stop_clk;
        state_r == lpmw_pkg::ST_STOP |-> !OSC_EN && !PERIPH_CLK_EN && !CPU_CLK_EN;
    endproperty
    a_stop_clk: assert property (p_stop_clk) else $error("clock running in stop"); // R09
    property p_wait_clk;
        state_r == lpmw_pkg::ST_WAIT |-> OSC_EN && PERIPH_CLK_EN && !CPU_CLK_EN;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("wait clocks wrong"); // R06
    property p_wdg_subst;
        sleep_ok && CPU_SLEEP_STOP && WDG_ACTIVE && !(opt_r[0] && nmi_high)
            |=> state_r == lpmw_pkg::ST_WAIT ##1 !WDG_FREEZE;
    endproperty
    a_wdg_subst: assert property (p_wdg_subst) else $error("stop not replaced"); // R12
    property p_nogen;
        (state_r == lpmw_pkg::ST_WAIT || state_r == lpmw_pkg::ST_STOP) && !gie
            |=> state_r == $past(state_r);
    endproperty
    a_nogen: assert property (p_nogen) else $error("woke with gie low"); // R14

    property p_blocked;
        CPU_SLEEP && state_r == lpmw_pkg::ST_RUN && sleep_block |=> state_r == lpmw_pkg::ST_RUN;
    endproperty
    a_blocked: assert property (p_blocked) else $error("sleep taken while pending"); // R19

    property p_nmi_latch;
        nmi_fall |=> nmi_lat_r ##1 (nmi_lat_r || $past(clr_nmi));
    endproperty
    a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge lost"); // R22

    c_wait_wake: cover property (state_r == lpmw_pkg::ST_WAIT ##1 state_r == lpmw_pkg::ST_RUN);
    c_stop_full: cover property (state_r == lpmw_pkg::ST_WARM ##1 state_r == lpmw_pkg::ST_RUN);
    c_nmi_in_int: cover property (vec_ack && vkind_r == lpmw_pkg::VK_NMI
                                  && ctx_r == lpmw_pkg::CTX_INT);
    c_real_stop: cover property (WDG_FREEZE);

endmodule

// [lpmw_defines.svh]
`ifndef LPMW_DEFINES_SVH
`define LPMW_DEFINES_SVH

// register byte offsets
`define LPMW_OFS_IOPT       8'h00
`define LPMW_OFS_OPTION     8'h04
`define LPMW_OFS_STATUS     8'h08

// interrupt_option_register fields
`define LPMW_IOPT_LES_BIT   6
`define LPMW_IOPT_ESB_BIT   5
`define LPMW_IOPT_GIE_BIT   4
`define LPMW_IOPT_RESET     8'h00

// option register fields
`define LPMW_OPT_EXSTOP_BIT 0
`define LPMW_OPT_AUXOSC_BIT 1
`define LPMW_OPT_RESET      2'h0

// vector addresses (low byte of each pair)
`define LPMW_VEC_RST        12'hffe
`define LPMW_VEC_NMI        12'hffc
`define LPMW_VEC_PORTA      12'hff6
`define LPMW_VEC_PORTBC     12'hff4
`define LPMW_VEC_TIMER      12'hff2
`define LPMW_VEC_CONV       12'hff0

// oscillator start-up delay after stop, in internal clock cycles
`define LPMW_WARM_CYC       2048
`define LPMW_WARM_W         12
`define LPMW_WARM_LOAD      12'h7ff

`endif

// [lpmw_pkg.sv]
package lpmw_pkg;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_WARM
    } lpmw_state_e;

    typedef enum logic [1:0] {
        CTX_MAIN,
        CTX_INT,
        CTX_NMI
    } lpmw_ctx_e;

    typedef enum logic [2:0] {
        VK_RST,
        VK_NMI,
        VK_PORTA,
        VK_PORTBC,
        VK_TIMER,
        VK_CONV
    } lpmw_vkind_e;

endpackage
